// ---- logic/bcd_command_decoder.sv ----
// Command decoder, read pointer and flag registers of the bridge.
`timescale 1ns/1ps
`include "bcd_defs.svh"
module bcd_command_decoder
#(
  parameter int RESET_CYCLES   = `BCD_RESET_CYCLES,
  parameter int RELEASE_CYCLES = `BCD_RELEASE_CYCLES
)
(
  // Clock, reset and clock enable
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       clkEn,
  // Byte stream from the serial framing logic
  input  wire logic       scl,
  input  wire logic       byteValid,
  input  wire logic [7:0] byteData,
  input  wire logic       firstByte,
  input  wire logic       ackSlot,
  // Acknowledge decision for the byte just received
  output logic            ackOk,
  // Line sequencer handshake
  input  wire logic       lineDone,
  input  wire logic       linePresence,
  input  wire logic       lineShort,
  input  wire logic       lineBit,
  input  wire logic       lineSecond,
  input  wire logic       lineDir,
  input  wire logic       lineLevel,
  input  wire logic [7:0] lineData,
  output logic            lineStart,
  output logic [2:0]      lineCmd,
  output logic [7:0]      lineParam,
  output logic            lineAbort,
  output logic            lineReleased,
  // Register views
  output logic [7:0]      bridgeFlags,
  output logic [7:0]      receivedByte,
  output logic [7:0]      lineSettings,
  output logic [7:0]      readValue,
  output logic [1:0]      readPointer,
  output logic            resetActive
);
  logic sclRise;
  logic sclFall;
  logic [7:0] pendCmd;
  logic       pendValid;
  logic       pendAck;
  logic [7:0] pendParam;
  logic       paramStage;
  logic       resetArm;
  logic [9:0] resetCnt;
  logic       lineBusy;
  logic       resetFlag;
  logic       presenceFound;
  logic       shortFound;
  logic       singleBitResult;
  logic       tripletSecondBit;
  logic       branchDir;
  logic       logicLevel;
  logic [3:0] cfgNib;
  logic [2:0] activeCmd;
  logic       resetDo;
  logic       cfgOk;
  logic       ptrOk;
  logic       paramOk;
  logic       cmdKnown;
  logic       needsParam;
  bcd_pkg::bcd_ptr_e ptr;
  bcd_pkg::bcd_ptr_e next_ptr;

  bcd_edge_detect sclEdges
  (
    .core_clk (core_clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .level    (scl),
    .rise     (sclRise),
    .fall     (sclFall)
  );

  always_comb
  begin
    cmdKnown = 1'b0;
    needsParam = 1'b0;
    case (byteData)
      `BCD_CMD_DEVICE_RESET, `BCD_CMD_LINE_RESET, `BCD_CMD_READ_BYTE:
        cmdKnown = 1'b1;
      `BCD_CMD_SET_POINTER, `BCD_CMD_WRITE_CONFIG, `BCD_CMD_SINGLE_BIT,
      `BCD_CMD_WRITE_BYTE, `BCD_CMD_TRIPLET:
      begin
        cmdKnown = 1'b1;
        needsParam = 1'b1;
      end
      default:
        cmdKnown = 1'b0;
    endcase
  end

  // Line commands other than device reset and pointer set need an idle line.
  function automatic logic needsIdle(input logic [7:0] c);
    needsIdle = (c != `BCD_CMD_DEVICE_RESET) && (c != `BCD_CMD_SET_POINTER);
  endfunction : needsIdle

  assign ptrOk = (byteData == `BCD_PTR_STATUS) || (byteData == `BCD_PTR_READ_DATA) ||
                 (byteData == `BCD_PTR_CONFIG);
  assign cfgOk = (byteData[7:4] == ~byteData[3:0]);
  assign paramOk = (pendCmd == `BCD_CMD_SET_POINTER) ? ptrOk :
                   (pendCmd == `BCD_CMD_WRITE_CONFIG) ? cfgOk : 1'b1;

  // Decide the acknowledge as each byte completes.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ackOk <= 1'b0;
      pendValid <= 1'b0;
      pendAck <= 1'b0;
      pendCmd <= 8'h00;
      pendParam <= 8'h00;
      paramStage <= 1'b0;
    end
    else if (clkEn)
    begin
      if (byteValid)
      begin
        if (firstByte || !paramStage)
        begin
          pendCmd <= byteData;
          pendParam <= 8'h00;
          if (!cmdKnown)
            ackOk <= 1'b0;
          else if (needsIdle(byteData) && lineBusy)
            ackOk <= 1'b0;
          else
            ackOk <= 1'b1;
          pendAck <= cmdKnown && !(needsIdle(byteData) && lineBusy);
          pendValid <= cmdKnown && !needsParam && !(needsIdle(byteData) && lineBusy);
          paramStage <= cmdKnown && needsParam;
        end
        else
        begin
          pendParam <= byteData;
          paramStage <= 1'b0;
          // A command refused while the line is busy still owns its parameter, so that byte is refused too.
          ackOk <= pendAck && paramOk;
          pendValid <= pendAck && paramOk;
        end
      end
      else if (ackSlot && sclFall)
        pendValid <= 1'b0;
    end
  end

  // Commands take effect on the rising SCL edge of their acknowledge bit.
  assign resetDo = clkEn && ackSlot && sclRise && pendValid &&
                   (pendCmd == `BCD_CMD_DEVICE_RESET);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      resetArm <= 1'b0;
      resetCnt <= 10'h000;
      resetActive <= 1'b0;
      lineAbort <= 1'b0;
      lineReleased <= 1'b1;
    end
    else if (clkEn)
    begin
      if (resetDo)
      begin
        resetArm <= 1'b1;
        lineAbort <= 1'b1;
        lineReleased <= 1'b0;
      end
      if (resetArm && ackSlot == 1'b0)
      begin
        resetArm <= 1'b0;
        resetActive <= 1'b1;
        resetCnt <= 10'h000;
      end
      if (resetActive)
      begin
        resetCnt <= resetCnt + 10'h001;
        if (resetCnt == 10'(RELEASE_CYCLES - 2))
        begin
          lineAbort <= 1'b0;
          lineReleased <= 1'b1;
        end
        if (resetCnt == 10'(RESET_CYCLES - 2))
          resetActive <= 1'b0;
      end
    end
  end

  // Read pointer.
  always_comb
  begin
    next_ptr = ptr;
    if (clkEn && ackSlot && sclRise && pendValid)
    begin
      case (pendCmd)
        `BCD_CMD_SET_POINTER:
        begin
          case (pendParam)
            `BCD_PTR_READ_DATA: next_ptr = bcd_pkg::PtrReadData;
            `BCD_PTR_CONFIG: next_ptr = bcd_pkg::PtrConfig;
            default: next_ptr = bcd_pkg::PtrStatus;
          endcase
        end
        `BCD_CMD_WRITE_CONFIG: next_ptr = bcd_pkg::PtrConfig;
        default: next_ptr = bcd_pkg::PtrStatus;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ptr <= bcd_pkg::PtrStatus;
    else if (clkEn)
      ptr <= resetDo ? bcd_pkg::PtrStatus : next_ptr;
  end

  // Configuration nibble; strong pullup drops when a line reset, read byte or triplet command launches.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cfgNib <= `BCD_CFG_RESET;
    else if (clkEn)
    begin
      if (resetDo)
        cfgNib <= `BCD_CFG_RESET;
      else if (ackSlot && sclRise && pendValid && pendCmd == `BCD_CMD_WRITE_CONFIG)
        cfgNib <= {pendParam[3:2], 1'b0, pendParam[0]};
      else if (lineStart && activeCmd != bcd_pkg::LineWrite &&
               activeCmd != bcd_pkg::LineSingle)
        cfgNib[`BCD_CFG_STRONG_PU] <= 1'b0;
    end
  end

  // Line command launch and busy flag.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      lineStart <= 1'b0;
      lineCmd <= 3'(bcd_pkg::LineNone);
      lineParam <= 8'h00;
      lineBusy <= 1'b0;
      activeCmd <= 3'(bcd_pkg::LineNone);
    end
    else if (clkEn)
    begin
      lineStart <= 1'b0;
      if (resetDo)
      begin
        lineBusy <= 1'b0;
        activeCmd <= 3'(bcd_pkg::LineNone);
      end
      else if (ackSlot && sclRise && pendValid && !lineBusy)
      begin
        case (pendCmd)
          `BCD_CMD_LINE_RESET: activeCmd <= 3'(bcd_pkg::LineReset);
          `BCD_CMD_SINGLE_BIT: activeCmd <= 3'(bcd_pkg::LineSingle);
          `BCD_CMD_WRITE_BYTE: activeCmd <= 3'(bcd_pkg::LineWrite);
          `BCD_CMD_READ_BYTE: activeCmd <= 3'(bcd_pkg::LineRead);
          `BCD_CMD_TRIPLET: activeCmd <= 3'(bcd_pkg::LineTriplet);
          default: activeCmd <= 3'(bcd_pkg::LineNone);
        endcase
        case (pendCmd)
          `BCD_CMD_LINE_RESET, `BCD_CMD_SINGLE_BIT, `BCD_CMD_WRITE_BYTE,
          `BCD_CMD_READ_BYTE, `BCD_CMD_TRIPLET:
          begin
            lineBusy <= 1'b1;
            lineStart <= 1'b1;
            lineParam <= pendParam;
          end
          default: lineBusy <= lineBusy;
        endcase
      end
      else if (lineBusy && lineDone)
        lineBusy <= 1'b0;
      if (lineStart)
        lineCmd <= activeCmd;
    end
  end

  // Status flags written back by the line sequencer.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      resetFlag <= 1'b1;
      presenceFound <= 1'b0;
      shortFound <= 1'b0;
      singleBitResult <= 1'b0;
      tripletSecondBit <= 1'b0;
      branchDir <= 1'b0;
      logicLevel <= 1'b0;
      receivedByte <= 8'h00;
    end
    else if (clkEn)
    begin
      logicLevel <= lineLevel;
      if (resetDo)
      begin
        resetFlag <= 1'b1;
        presenceFound <= 1'b0;
        shortFound <= 1'b0;
        singleBitResult <= 1'b0;
        tripletSecondBit <= 1'b0;
        branchDir <= 1'b0;
      end
      else
      begin
        if (ackSlot && sclRise && pendValid && pendCmd == `BCD_CMD_WRITE_CONFIG)
          resetFlag <= 1'b0;
        if (lineBusy && lineDone)
        begin
          case (activeCmd)
            3'(bcd_pkg::LineReset):
            begin
              presenceFound <= linePresence && !lineShort;
              shortFound <= lineShort;
            end
            3'(bcd_pkg::LineSingle): singleBitResult <= lineBit;
            3'(bcd_pkg::LineRead): receivedByte <= lineData;
            3'(bcd_pkg::LineTriplet):
            begin
              singleBitResult <= lineBit;
              tripletSecondBit <= lineSecond;
              branchDir <= lineDir;
            end
            default: receivedByte <= receivedByte;
          endcase
        end
      end
    end
  end

  // Registered register views and the byte at the read pointer.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bridgeFlags <= 8'h10;
      lineSettings <= 8'h00;
      readValue <= 8'h10;
      readPointer <= 2'h0;
    end
    else if (clkEn)
    begin
      bridgeFlags <= {branchDir, tripletSecondBit, singleBitResult, resetFlag,
                      logicLevel, shortFound, presenceFound, lineBusy};
      lineSettings <= {4'h0, cfgNib};
      readPointer <= 2'(ptr);
      case (ptr)
        bcd_pkg::PtrReadData: readValue <= receivedByte;
        bcd_pkg::PtrConfig: readValue <= {4'h0, cfgNib};
        default: readValue <= {branchDir, tripletSecondBit, singleBitResult, resetFlag,
                               logicLevel, shortFound, presenceFound, lineBusy};
      endcase
    end
  end
endmodule : bcd_command_decoder

// ---- logic/bcd_defs.svh ----
// Constants for the bridge command decoder: codes, fields, reset values and timing.
// Notes on behaviour
// - Second-bit flag takes triplet second slot level
// - Direction flag takes triplet third slot choice
// - Exactly eight function command codes are recognised
// - Accepted command moves pointer to relevant register
// - Acknowledge valid bytes, withhold for invalid ones
// - Pointer codes F0h, E1h, C3h select registers
// - F0h resets all state, aborts line, always; receivedByte is kept
// - Global reset completes within 525 ns
// - Line released within 262.5 ns of reset
// - Reset sets reset flag, clears others, points status
// - Reset clears speed, active and strong pullup
// - E1h plus code moves pointer at any time
// - Invalid pointer code: no acknowledge, pointer kept
// - Pointer updates on acknowledge rising SCL edge
// - D2h plus byte loads settings, no line activity
// - Config upper nibble must invert lower nibble
// - Config reads back zero upper nibble
// - Busy line refuses config command and byte
// - Config commits on acknowledge rising SCL edge
// - Config write clears reset flag, points config
// - Busy flag high while line command runs
`ifndef BCD_DEFS_SVH
`define BCD_DEFS_SVH

`define BCD_CMD_DEVICE_RESET 8'hF0
`define BCD_CMD_SET_POINTER  8'hE1
`define BCD_CMD_WRITE_CONFIG 8'hD2
`define BCD_CMD_LINE_RESET   8'hB4
`define BCD_CMD_SINGLE_BIT   8'h87
`define BCD_CMD_WRITE_BYTE   8'hA5
`define BCD_CMD_READ_BYTE    8'h96
`define BCD_CMD_TRIPLET      8'h78

`define BCD_PTR_STATUS       8'hF0
`define BCD_PTR_READ_DATA    8'hE1
`define BCD_PTR_CONFIG       8'hC3

`define BCD_ST_BUSY          0
`define BCD_ST_PRESENCE      1
`define BCD_ST_SHORT         2
`define BCD_ST_LEVEL         3
`define BCD_ST_RESET         4
`define BCD_ST_SINGLE        5
`define BCD_ST_SECOND        6
`define BCD_ST_DIR           7

`define BCD_CFG_ACTIVE_PU    0
`define BCD_CFG_STRONG_PU    2
`define BCD_CFG_SPEED        3
`define BCD_CFG_RESET        4'h0

`define BCD_CLK_PERIOD_PS    8000
`define BCD_RESET_MAX_PS     525000
`define BCD_RELEASE_MAX_PS   262500
`define BCD_RESET_CYCLES     (`BCD_RESET_MAX_PS / `BCD_CLK_PERIOD_PS)
`define BCD_RELEASE_CYCLES   (`BCD_RELEASE_MAX_PS / `BCD_CLK_PERIOD_PS)

`endif

// ---- logic/bcd_pkg.sv ----
// Types shared by the bridge command decoder.
package bcd_pkg;
  typedef enum logic [1:0] {PtrStatus, PtrReadData, PtrConfig} bcd_ptr_e;
  typedef enum logic [2:0] {
    LineNone, LineReset, LineSingle, LineWrite, LineRead, LineTriplet
  } bcd_line_e;
endpackage : bcd_pkg

// ---- logic/bcd_edge_detect.sv ----
// Rising and falling edge detector for a synchronous input.
`timescale 1ns/1ps
module bcd_edge_detect
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clkEn,
  // Sampled level and edges
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic last;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      last <= 1'b1;
    else if (clkEn)
      last <= level;
  end

  assign rise = clkEn && level && !last;
  assign fall = clkEn && !level && last;
endmodule : bcd_edge_detect

// ---- dv/bcd_command_decoder_asserts.sv ----
// Concurrent checks on the command decoder ports.
`timescale 1ns/1ps
module bcd_command_decoder_asserts
#(
  parameter int RESET_CYCLES   = 65,
  parameter int RELEASE_CYCLES = 32
)
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       clkEn,
  // Byte stream and acknowledge
  input wire logic       scl,
  input wire logic       byteValid,
  input wire logic [7:0] byteData,
  input wire logic       firstByte,
  input wire logic       ackSlot,
  input wire logic       ackOk,
  // Line sequencer
  input wire logic       lineDone,
  input wire logic       lineSecond,
  input wire logic       lineDir,
  input wire logic       lineStart,
  input wire logic [2:0] lineCmd,
  input wire logic       lineAbort,
  input wire logic       lineReleased,
  // Register views
  input wire logic [7:0] bridgeFlags,
  input wire logic [7:0] lineSettings,
  input wire logic [1:0] readPointer,
  input wire logic       resetActive
);
  localparam int REL_MAX = RELEASE_CYCLES + 2;
  localparam int RST_MAX = RESET_CYCLES;
  logic [7:0] lastCmd;
  logic [7:0] lastByte;
  logic       lastFirst;
  logic       startD;
  logic [2:0] lastLine;
  logic [1:0] tripRes;

  default clocking cb @(posedge core_clk);
  endclocking
  // Frozen cycles are not judged; the design holds all state then.
  default disable iff (rst || !clkEn);

  function automatic logic [1:0] ptrOf(input logic [7:0] c);
    return (c == 8'hF0) ? 2'h0 : (c == 8'hE1) ? 2'h1 : 2'h2;
  endfunction : ptrOf

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      lastCmd   <= 8'h00;
      lastByte  <= 8'h00;
      lastFirst <= 1'b0;
    end
    else if (byteValid && clkEn)
    begin
      lastByte  <= byteData;
      lastFirst <= firstByte;
      if (firstByte)
        lastCmd <= byteData;
    end

  // The command code is only qualified one cycle after launch.
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      startD   <= 1'b0;
      lastLine <= 3'h0;
      tripRes  <= 2'h0;
    end
    else
    begin
      startD <= lineStart;
      if (startD)
        lastLine <= lineCmd;
      if (lineDone)
        tripRes <= {lineDir, lineSecond};
    end

  a_cfg_read_zero: assert property (
    lineSettings[7:4] == 4'h0 && !lineSettings[1])
    else $error("config upper nibble not zero");
  a_unknown_no_ack: assert property (
    byteValid && firstByte &&
    !(byteData inside {8'hF0, 8'hE1, 8'hD2, 8'hB4, 8'h87, 8'hA5, 8'h96, 8'h78}) |=> !ackOk)
    else $error("unknown command acknowledged");
  a_bad_ptr_nak: assert property (
    byteValid && !firstByte && ackOk && lastCmd == 8'hE1 &&
    !(byteData inside {8'hF0, 8'hE1, 8'hC3}) |=> !ackOk)
    else $error("bad pointer code acknowledged");
  a_cfg_nibble_nak: assert property (
    byteValid && !firstByte && ackOk && lastCmd == 8'hD2 &&
    byteData[7:4] != ~byteData[3:0] |=> !ackOk)
    else $error("bad config byte acknowledged");
  a_busy_cfg_nak: assert property (
    byteValid && firstByte && byteData == 8'hD2 && bridgeFlags[0] && !$past(lineDone)
    |=> !ackOk)
    else $error("config accepted while busy");
  a_busy_param_nak: assert property (
    byteValid && !firstByte && lastFirst && lastCmd == 8'hD2 && !ackOk |=> !ackOk)
    else $error("parameter of refused config accepted");
  a_reset_cmd_ack: assert property (
    byteValid && firstByte && byteData == 8'hF0 |=> ackOk)
    else $error("device reset not acknowledged");
  a_line_release: assert property (
    lineAbort && $fell(scl) |-> ##[1:REL_MAX] lineReleased)
    else $error("line not released in time");
  a_reset_bound: assert property (
    $rose(resetActive) |-> ##[1:RST_MAX] !resetActive)
    else $error("device reset too long");
  a_cfg_commit: assert property (
    ackSlot && $rose(scl) && ackOk && !lastFirst &&
    lastCmd == 8'hD2 |-> ##[1:3] (lineSettings == {4'h0, lastByte[3:2], 1'b0, lastByte[0]}
    && readPointer == 2'h2 && !bridgeFlags[4]))
    else $error("config write not committed");
  a_ptr_update: assert property (
    ackSlot && $rose(scl) && ackOk && !lastFirst &&
    lastCmd == 8'hE1 |-> ##[1:3] readPointer == ptrOf(lastByte))
    else $error("pointer not updated");
  a_busy_while_run: assert property (
    lineStart |-> ##[1:3] bridgeFlags[0])
    else $error("busy flag not raised");
  a_triplet_flags: assert property (
    lineDone && lastLine == 3'h5 && !lineAbort |-> ##[1:3] bridgeFlags[7:6] == tripRes)
    else $error("triplet flags wrong");

  c_reset_cmd: cover property (lineAbort && $fell(scl));
  c_triplet: cover property (lineDone && lastLine == 3'h5);
  c_busy_cfg: cover property (byteValid && firstByte && byteData == 8'hD2 && bridgeFlags[0]);
endmodule : bcd_command_decoder_asserts

bind bcd_command_decoder bcd_command_decoder_asserts #(
  .RESET_CYCLES(RESET_CYCLES),
  .RELEASE_CYCLES(RELEASE_CYCLES)
) u_chk (.core_clk, .rst, .clkEn, .scl, .byteValid, .byteData, .firstByte, .ackSlot, .ackOk,
  .lineDone, .lineSecond, .lineDir, .lineStart, .lineCmd, .lineAbort, .lineReleased,
  .bridgeFlags, .lineSettings, .readPointer, .resetActive);

// ---- dv/bcd_line_model.sv ----
// Behavioural line sequencer that answers the decoder's launch requests.
`timescale 1ns/1ps
module bcd_line_model
#(
  parameter int DURATION = 80
)
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Launch and abort
  input  wire logic       lineStart,
  input  wire logic [7:0] lineParam,
  input  wire logic       lineAbort,
  // Results
  output logic            lineDone,
  output logic            linePresence,
  output logic            lineShort,
  output logic            lineBit,
  output logic            lineSecond,
  output logic            lineDir,
  output logic            lineLevel,
  output logic [7:0]      lineData
);
  logic [7:0]  cnt;
  logic [12:0] resV;

  // Results are only valid with lineDone; otherwise the inverse shows.
  assign {lineData, lineDir, lineSecond, lineBit, lineShort, linePresence} =
    lineDone ? resV : ~resV;
  assign lineLevel = 1'b1;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      cnt      <= 8'h00;
      lineDone <= 1'b0;
    end
    else
    begin
      lineDone <= (cnt == 8'h01) && !lineAbort;
      if (lineAbort)
        cnt <= 8'h00;
      else if (lineStart)
        cnt <= 8'(DURATION);
      else if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
    end

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      resV <= 13'h0000;
    else if (cnt == 8'(DURATION - 1))
      resV <= {lineParam ^ 8'h5A, 5'h15};
endmodule : bcd_line_model

// ---- dv/bcd_command_decoder_bench.sv ----
// Self-checking bench for the bridge command decoder.
`timescale 1ns/1ps
module bcd_command_decoder_bench;
  typedef struct packed
  {
    logic [7:0] cmd;
    logic [7:0] prm;
    logic [3:0] flg;
    logic [3:0] ptr;
    logic [3:0] cfg;
  } bcd_row_s;
  // Flag nibble: two bytes, first ack, second ack, line command.
  bcd_row_s rows [14] = '{28'hE1E1E10, 28'hE1C3E20, 28'hE1F0E00, 28'hE155C00,
    28'hD21EE2C, 28'hD2E1E21, 28'hD2F1C21, 28'h5A00021, 28'h0000021, 28'hB400501,
    28'h8780F01, 28'hA533F01, 28'h9600501, 28'h7880F01};
  logic core_clk, rst, clkEn, scl, byteValid, firstByte, ackSlot, ackOk;
  logic lineDone, linePresence, lineShort, lineBit, lineSecond, lineDir, lineLevel;
  logic lineStart, lineAbort, lineReleased, resetActive;
  logic [7:0] byteData, lineData, lineParam, bridgeFlags, receivedByte, lineSettings;
  logic [7:0] readValue;
  logic [2:0] lineCmd;
  logic [1:0] readPointer;
  int failures = 0;
  int checked = 0;

  bcd_command_decoder u_dut (.core_clk, .rst, .clkEn, .scl, .byteValid, .byteData,
    .firstByte, .ackSlot, .ackOk, .lineDone, .linePresence, .lineShort, .lineBit,
    .lineSecond, .lineDir, .lineLevel, .lineData, .lineStart, .lineCmd, .lineParam,
    .lineAbort, .lineReleased, .bridgeFlags, .receivedByte, .lineSettings, .readValue,
    .readPointer, .resetActive);
  bcd_line_model u_line (.core_clk, .rst, .lineStart, .lineParam, .lineAbort, .lineDone,
    .linePresence, .lineShort, .lineBit, .lineSecond, .lineDir, .lineLevel, .lineData);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // One byte with its acknowledge slot; effects land on the slot's rising clock line.
  task automatic sendByte(input logic [7:0] d, input logic f, input logic a);
    @(posedge core_clk);
    #1 byteValid = 1'b1;
    byteData = d;
    firstByte = f;
    @(posedge core_clk);
    #1 byteValid = 1'b0;
    @(posedge core_clk);
    #1 check(ackOk, a);
    ackSlot = 1'b1;
    @(posedge core_clk);
    #1 scl = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 scl = 1'b0;
    @(posedge core_clk);
    #1 ackSlot = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : sendByte

  task automatic waitIdle();
    for (int i = 0; i < 400 && bridgeFlags[0] !== 1'b0; i++)
      @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    #1;
  endtask : waitIdle

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_sim();
  end

  initial
  begin
    {clkEn, scl, byteValid, firstByte, ackSlot, byteData} = {1'b1, 4'h0, 8'h00};
    rst = 1'b1;
    repeat (6) @(posedge core_clk);
    #1 check(bridgeFlags, 8'h10);
    check(readValue, 8'h10);
    check(lineSettings, 8'h00);
    check(readPointer, 8'h00);
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    foreach (rows[i])
    begin
      sendByte(rows[i].cmd, 1'b1, rows[i].flg[2]);
      if (rows[i].flg[3])
        sendByte(rows[i].prm, 1'b0, rows[i].flg[1]);
      if (rows[i].flg[0])
      begin
        check(bridgeFlags[0], 1'b1);
        waitIdle();
      end
      check(readPointer, rows[i].ptr);
      check(lineSettings, {4'h0, rows[i].cfg});
    end
    check(bridgeFlags & 8'hF7, 8'hA2);
    check(receivedByte, 8'h5A);
    // Busy line: configuration and its byte are refused but the pointer still moves.
    sendByte(8'h78, 1'b1, 1'b1);
    sendByte(8'h80, 1'b0, 1'b1);
    sendByte(8'hD2, 1'b1, 1'b0);
    sendByte(8'hF0, 1'b0, 1'b0);
    sendByte(8'hE1, 1'b1, 1'b1);
    sendByte(8'hE1, 1'b0, 1'b1);
    check(readPointer, 8'h01);
    waitIdle();
    check(readPointer, 8'h01);
    check(readValue, 8'h5A);
    // Frozen clock enable: a whole pointer command must leave no trace.
    clkEn = 1'b0;
    sendByte(8'hE1, 1'b1, 1'b1);
    sendByte(8'hC3, 1'b0, 1'b1);
    clkEn = 1'b1;
    check(readPointer, 8'h01);
    // Device reset in the middle of a running line reset.
    sendByte(8'hD2, 1'b1, 1'b1);
    sendByte(8'h3C, 1'b0, 1'b1);
    sendByte(8'hB4, 1'b1, 1'b1);
    sendByte(8'hF0, 1'b1, 1'b1);
    for (int i = 0; i < 200 && resetActive !== 1'b0; i++)
      @(posedge core_clk);
    #1 check(lineReleased, 1'b1);
    check(bridgeFlags & 8'hF7, 8'h10);
    check(lineSettings, 8'h00);
    check(readPointer, 8'h00);
    end_sim();
  end
endmodule : bcd_command_decoder_bench
